//--- tkdf_acq_model.sv
// Acquisition engine stand-in answering burst requests from a signal table
`timescale 1ns/1ps
`default_nettype none
module tkdf_acq_model
  import tkdf_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      burst_req_i,
  input  wire logic [KEY_W-1:0]          burst_key_i,
  input  wire logic [NUM_KEYS*SIG_W-1:0] sig_tab_i,
  input  wire logic                      slow_i,
  output logic                           acq_valid_o,
  output logic      [SIG_W-1:0]          acq_signal_o
);
  int k;
  // One burst in flight; result bus toggles outside valid so stale data never matches
  always begin
    @(posedge clk_i);
    if (reset_i) begin
      acq_valid_o <= 1'b0;
      acq_signal_o <= '0;
    end else begin
      if (burst_req_i === 1'b1) begin
        k = int'(burst_key_i);
        if (slow_i) repeat (5) @(posedge clk_i);
        acq_valid_o <= 1'b1;
        acq_signal_o <= sig_tab_i[k*SIG_W +: SIG_W];
        @(posedge clk_i);
        acq_valid_o <= 1'b0;
      end
      acq_signal_o <= ~acq_signal_o;
    end
  end
endmodule // tkdf_acq_model
`default_nettype wire

//--- tkdf_filter.sv
// Touch key drift tracking, detection integrators and stuck-key recalibration
//
// Notes on behaviour
// - Reference creeps toward the raw signal only while the key has no detection.
// - Reference moves one count per step; threshold and hysteresis follow it.
// - Tracking pauses once the signal crosses the threshold, resumes above it.
// - Upward and downward drift periods come from separate per-key setup codes.
// - Downward code defaults to 10, one count per 2.5 seconds.
// - Upward code defaults to 4, 0.6 seconds per count, via lookup table.
// - Normal limit 0 disables the key and drops it from the scan.
// - A key below threshold is re-burst until fast limit or failure, then next.
// - Each key has its own fast counter and limit from 1 to 15.
// - Fast counter counts up at or below threshold, clears above it.
// - Normal counter steps when fast limit is hit, once per scan at most.
// - Key goes active when its normal counter reaches its normal limit.
// - Fast limit 1 gives one burst per key per rotation.
// - Defaults: normal limit 2, fast limit 5.
// - A per-key timer recalibrates a key detected longer than its delay.
// - After recalibration the key detects afresh against the new reference.
// - Delay 0 never auto-recalibrates; host recalibration still works.
// - Delay is one byte, 0 to 254 in half seconds; 255 is illegal.
// - Threshold in counts is the setup code plus 4 below the reference.
`timescale 1ns/1ps
`default_nettype none
module tkdf_filter
  import tkdf_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   burst_req_o,
  output logic      [KEY_W-1:0]  burst_key_o,
  input  wire logic              acq_valid_i,
  input  wire logic [SIG_W-1:0]  acq_signal_i,
  output logic      [NUM_KEYS-1:0] key_active_o,
  output logic                   recal_o,
  output logic      [KEY_W-1:0]  recal_key_o,
  output logic                   scan_done_o
);

  typedef enum logic [1:0] {B_IDLE, B_FETCH, B_ANSWER} tkdf_bus_t;
  typedef enum logic [2:0] {E_IDLE, E_NEXT, E_SETUP, E_REQ, E_WAIT, E_PROC} tkdf_eng_t;

  localparam logic [KEY_W-1:0] LAST_KEY = KEY_W'(NUM_KEYS - 1);

  tkdf_mem_if mif ();

  tkdf_bus_t              bus_r;
  tkdf_eng_t              eng_r;
  logic                   scan_en_r;
  logic                   calall_pend_r;
  logic [NUM_KEYS-1:0]    key_en_r;
  logic [KEY_W-1:0]       key_r;
  logic [SIG_W-1:0]       sig_r;
  logic [SIG_W-1:0]       ref_r       [NUM_KEYS];
  logic [3:0]             fast_cnt_r  [NUM_KEYS];
  logic [7:0]             norm_cnt_r  [NUM_KEYS];
  logic [DCNT_W-1:0]      drift_cnt_r [NUM_KEYS];
  logic [RCNT_W-1:0]      recal_cnt_r [NUM_KEYS];
  logic [NUM_KEYS-1:0]    ninc_done_r;
  logic [NUM_KEYS-1:0]    cal_pend_r;
  logic [NUM_KEYS-1:0]    drift_clr;
  logic                   tick;
  logic                   in_setup;
  logic                   in_misc;
  logic                   in_ref;
  logic [4:0]             word_idx;
  logic                   calall_take;
  logic                   proc_fire;
  logic [31:0]            rd_mux;

  // Decisions for the key being processed
  logic [31:0]            su;
  logic [SIG_W-1:0]       thr;
  logic [SIG_W-1:0]       lvl;
  logic                   below;
  logic [3:0]             flim;
  logic                   fast_hit;
  logic [7:0]             nlim;
  logic                   norm_hit;
  logic [7:0]             stuck_recal_delay;
  logic [RCNT_W-1:0]      recal_lim;
  logic                   stuck;
  logic                   go_up;
  logic [DCNT_W-1:0]      per;
  logic                   drift_due;
  logic                   recal_now;

  tkdf_tick #(
    .CYCLES (TICK_CYCLES_P)
  ) u_tick (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_o  (tick)
  );

  tkdf_setup_mem u_mem (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .mem     (mif.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: two-cycle answer, waitrequest idles high

  assign word_idx    = avs_address_i[6:2];
  assign in_setup    = (avs_address_i[9:7] == REGION_SETUP) && (int'(word_idx) < NUM_KEYS);
  assign in_misc     = (avs_address_i[9:7] == REGION_MISC);
  assign in_ref      = (avs_address_i[9:7] == REGION_REF) && (int'(word_idx) < NUM_KEYS);
  assign mif.a_idx   = word_idx;
  assign mif.a_we    = (bus_r == B_ANSWER) && avs_write_i && in_setup;
  assign calall_take = (eng_r == E_NEXT) && (key_r == LAST_KEY);

  // Byte-lane merge over the stored word
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      mif.a_wdata[b*8 +: 8] = avs_byteenable_i[b] ? avs_writedata_i[b*8 +: 8] : mif.a_rdata[b*8 +: 8];
    end
  end

  always_comb begin
    rd_mux = '0;
    if (in_setup) begin
      rd_mux = mif.a_rdata;
    end else if (in_misc && (word_idx == CTRL_WORD)) begin
      rd_mux = {30'h0000_0000, calall_pend_r, scan_en_r};
    end else if (in_misc && (word_idx == ACTIVE_WORD)) begin
      rd_mux = {{(32 - NUM_KEYS){1'b0}}, key_active_o};
    end else if (in_ref) begin
      rd_mux = {16'h0000, ref_r[word_idx]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_r             <= B_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else begin
      unique case (bus_r)
        B_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_r <= B_FETCH;
          end
        end
        B_FETCH: begin
          avs_readdata_o    <= avs_read_i ? rd_mux : '0;
          avs_waitrequest_o <= 1'b0;
          bus_r             <= B_ANSWER;
        end
        B_ANSWER: begin
          avs_waitrequest_o <= 1'b1;
          bus_r             <= B_IDLE;
        end
      endcase
    end
  end

  // Control bits; a recal-all request landing with the take is kept
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scan_en_r     <= 1'b1;
      calall_pend_r <= 1'b0;
    end else begin
      if (calall_take) begin
        calall_pend_r <= 1'b0;
      end
      if ((bus_r == B_ANSWER) && avs_write_i && in_misc && (word_idx == CTRL_WORD) && avs_byteenable_i[0]) begin
        scan_en_r <= avs_writedata_i[CTRL_SCAN_BIT];
        if (avs_writedata_i[CTRL_CALALL_BIT]) begin
          calall_pend_r <= 1'b1;
        end
      end
    end
  end

  // Enable mirror so the scan can skip keys without a memory read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      key_en_r <= '1;
    end else if (mif.a_we) begin
      key_en_r[word_idx] <= (mif.a_wdata[NL_LSB +: 8] != 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-key decision logic

  assign mif.b_idx = key_r;
  assign proc_fire = (eng_r == E_PROC);

  always_comb begin
    su        = mif.b_rdata;
    thr       = {12'h000, su[TT_LSB +: 4]} + THR_OFFSET;
    // Release needs the signal an eighth of the threshold clear of it
    lvl       = key_active_o[key_r] ? (thr - (thr >> 3)) : thr;
    below     = ({1'b0, sig_r} + {1'b0, lvl}) <= {1'b0, ref_r[key_r]};
    flim      = (su[FL_LSB +: 4] == 4'h0) ? 4'h1 : su[FL_LSB +: 4];
    fast_hit  = ({1'b0, fast_cnt_r[key_r]} + 5'h01) >= {1'b0, flim};
    nlim      = su[NL_LSB +: 8];
    norm_hit  = ({1'b0, norm_cnt_r[key_r]} + 9'h001) >= {1'b0, nlim};
    // An illegal 255 is held to the longest legal delay
    stuck_recal_delay       = (su[RD_LSB +: 8] == RECAL_BAD_CODE) ? RECAL_MAX_CODE : su[RD_LSB +: 8];
    recal_lim = RCNT_W'(int'(stuck_recal_delay) * RECAL_STEP_TICKS);
    stuck     = key_active_o[key_r] && (stuck_recal_delay != 8'h00) && (recal_cnt_r[key_r] >= recal_lim);
    go_up     = sig_r > ref_r[key_r];
    per       = go_up ? up_drift_ticks(su[UD_LSB +: 4])
                      : DCNT_W'(int'(su[DD_LSB +: 4]) * DOWN_STEP_TICKS);
    drift_due = !below && !key_active_o[key_r] && (sig_r != ref_r[key_r])
                && (drift_cnt_r[key_r] >= per);
    recal_now = cal_pend_r[key_r] || stuck;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-key timers on the base tick

  for (genvar g = 0; g < NUM_KEYS; g++) begin : g_key
    assign drift_clr[g] = proc_fire && (key_r == KEY_W'(g))
                          && (recal_now || below || key_active_o[g] || drift_due || (sig_r == ref_r[g]));

    // Drift period timer, cleared each time the key is processed while detected
    always_ff @(posedge clk_i) begin
      if (reset_i || drift_clr[g]) begin
        drift_cnt_r[g] <= '0;
      end else if (tick && (drift_cnt_r[g] != '1)) begin
        drift_cnt_r[g] <= drift_cnt_r[g] + DCNT_W'(1);
      end
    end

    // Detection duration timer
    always_ff @(posedge clk_i) begin
      if (reset_i || !key_active_o[g]) begin
        recal_cnt_r[g] <= '0;
      end else if (tick && (recal_cnt_r[g] != '1)) begin
        recal_cnt_r[g] <= recal_cnt_r[g] + RCNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      eng_r       <= E_IDLE;
      key_r       <= LAST_KEY;
      sig_r       <= '0;
      burst_req_o <= 1'b0;
      burst_key_o <= '0;
      scan_done_o <= 1'b0;
    end else begin
      burst_req_o <= 1'b0;
      scan_done_o <= 1'b0;
      unique case (eng_r)
        E_IDLE: begin
          key_r <= LAST_KEY;
          if (scan_en_r) begin
            eng_r <= E_NEXT;
          end
        end
        E_NEXT: begin
          if (key_r == LAST_KEY) begin
            key_r       <= '0;
            scan_done_o <= 1'b1;
            if (!scan_en_r) begin
              eng_r <= E_IDLE;
            end else if (key_en_r[0]) begin
              eng_r <= E_SETUP;
            end
          end else begin
            key_r <= key_r + KEY_W'(1);
            if (key_en_r[key_r + KEY_W'(1)]) begin
              eng_r <= E_SETUP;
            end
          end
        end
        E_SETUP: begin
          eng_r <= E_REQ;
        end
        E_REQ: begin
          burst_req_o <= 1'b1;
          burst_key_o <= key_r;
          eng_r       <= E_WAIT;
        end
        E_WAIT: begin
          if (acq_valid_i) begin
            sig_r <= acq_signal_i;
            eng_r <= E_PROC;
          end
        end
        E_PROC: begin
          // Stay locked on a key that is still confirming
          eng_r <= (!recal_now && below && !fast_hit) ? E_REQ : E_NEXT;
        end
        default: begin
          eng_r <= E_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-key state update

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ninc_done_r  <= '0;
      cal_pend_r   <= '1;
      key_active_o <= '0;
      recal_o      <= 1'b0;
      recal_key_o  <= '0;
      for (int i = 0; i < NUM_KEYS; i++) begin
        ref_r[i]      <= '0;
        fast_cnt_r[i] <= '0;
        norm_cnt_r[i] <= '0;
      end
    end else begin
      recal_o <= 1'b0;
      if (calall_take) begin
        ninc_done_r <= '0;
        if (calall_pend_r) begin
          cal_pend_r <= '1;
        end
      end
      if (proc_fire) begin
        if (recal_now) begin
          // Fresh reference, counters restart even if still covered
          ref_r[key_r]        <= sig_r;
          fast_cnt_r[key_r]   <= '0;
          norm_cnt_r[key_r]   <= '0;
          key_active_o[key_r] <= 1'b0;
          cal_pend_r[key_r]   <= 1'b0;
          recal_o             <= 1'b1;
          recal_key_o         <= key_r;
        end else if (below) begin
          if (!fast_hit) begin
            fast_cnt_r[key_r] <= fast_cnt_r[key_r] + 4'h1;
          end else begin
            fast_cnt_r[key_r] <= '0;
            if (!ninc_done_r[key_r]) begin
              ninc_done_r[key_r] <= 1'b1;
              if (norm_hit) begin
                norm_cnt_r[key_r]   <= nlim;
                key_active_o[key_r] <= 1'b1;
              end else begin
                norm_cnt_r[key_r] <= norm_cnt_r[key_r] + 8'h01;
              end
            end
          end
        end else begin
          fast_cnt_r[key_r]   <= '0;
          norm_cnt_r[key_r]   <= '0;
          key_active_o[key_r] <= 1'b0;
          if (drift_due) begin
            ref_r[key_r] <= go_up ? ref_r[key_r] + 16'h0001 : ref_r[key_r] - 16'h0001;
          end
        end
      end
    end
  end

endmodule // tkdf_filter
`default_nettype wire

//--- tkdf_filter_chk.sv
// Port level assertions for the touch key filter
`timescale 1ns/1ps
`default_nettype none
module tkdf_filter_chk
  import tkdf_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic                clk_i,
  input wire logic                reset_i,
  input wire logic [ADDR_W-1:0]   avs_address_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic [31:0]         avs_writedata_i,
  input wire logic [3:0]          avs_byteenable_i,
  input wire logic [31:0]         avs_readdata_o,
  input wire logic                avs_waitrequest_o,
  input wire logic                burst_req_o,
  input wire logic [KEY_W-1:0]    burst_key_o,
  input wire logic                acq_valid_i,
  input wire logic [SIG_W-1:0]    acq_signal_i,
  input wire logic [NUM_KEYS-1:0] key_active_o,
  input wire logic                recal_o,
  input wire logic [KEY_W-1:0]    recal_key_o,
  input wire logic                scan_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_bus_latency: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus answer late");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low twice");
  a_burst_pulse: assert property (burst_req_o |=> !burst_req_o) else $error("burst too long");
  a_burst_gap: assert property (acq_valid_i |=> !burst_req_o) else $error("burst too soon");
  a_key_range: assert property (burst_req_o |-> burst_key_o < NUM_KEYS) else $error("bad key");
  a_recal_cause: assert property (recal_o |-> $past(acq_valid_i, 2) && recal_key_o == burst_key_o)
    else $error("recal without result");
  a_recal_single: assert property (recal_o |=> !recal_o) else $error("recal too long");
  a_active_cause: assert property ($changed(key_active_o) |-> $past(acq_valid_i, 2) &&
    $onehot(key_active_o ^ $past(key_active_o))) else $error("active change without result");
  a_done_pulse: assert property (scan_done_o |=> !scan_done_o) else $error("scan done too long");
endmodule // tkdf_filter_chk
bind tkdf_filter tkdf_filter_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (.clk_i, .reset_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .burst_req_o, .burst_key_o, .acq_valid_i, .acq_signal_i, .key_active_o, .recal_o, .recal_key_o, .scan_done_o);
`default_nettype wire

//--- tkdf_filter_tb_top.sv
// Self-checking bench for the touch key filter
`timescale 1ns/1ps
`default_nettype none
module tkdf_filter_tb_top;
  import tkdf_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat, bq;
  logic wrq, breq, acqv, rcl, sdone, slow = 1'b0;
  logic [KEY_W-1:0] bkey, rkey;
  logic [SIG_W-1:0] acqs;
  logic [NUM_KEYS-1:0] act;
  logic [NUM_KEYS*SIG_W-1:0] stab = '0;
  logic [31:0] seed = 32'h892c_7aa2;
  int failures = 0;
  int checks_done = 0;
  int act5 = 0;
  int rf[NUM_KEYS], thr[NUM_KEYS], fl[NUM_KEYS], nl[NUM_KEYS], fc[NUM_KEYS], nc[NUM_KEYS], sg[NUM_KEYS];
  bit ac[NUM_KEYS], cal[NUM_KEYS], nf[NUM_KEYS];
  bit pend = 0;
  bit nochk = 0;
  always #25 clk_i = ~clk_i;
  tkdf_filter #(.TICK_CYCLES_P(20)) dut_u (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .burst_req_o(breq), .burst_key_o(bkey),
    .acq_valid_i(acqv), .acq_signal_i(acqs), .key_active_o(act), .recal_o(rcl), .recal_key_o(rkey),
    .scan_done_o(sdone));
  tkdf_acq_model acq_u (.clk_i(clk_i), .reset_i(reset_i), .burst_req_i(breq), .burst_key_i(bkey),
    .sig_tab_i(stab), .slow_i(slow), .acq_valid_o(acqv), .acq_signal_o(acqs));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int bs(int k);
    return 32'h0000_4000 + 16 * k;
  endfunction
  function automatic int nxt(int k);
    for (int j = 1; j <= NUM_KEYS; j++) if (nl[(k + j) % NUM_KEYS] != 0) return (k + j) % NUM_KEYS;
    return k;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wrq !== 1'b0 && n < 40);
    bq = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) chk("waitrequest", 0, 1);
  endtask
  task automatic put();
    logic [NUM_KEYS*SIG_W-1:0] v;
    for (int k = 0; k < NUM_KEYS; k++) v[k*SIG_W +: SIG_W] = 16'(sg[k]);
    stab <= v;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reference model, one update per acquisition result
  always @(posedge clk_i) act5 <= act[5] ? act5 + 1 : 0;
  always @(posedge clk_i) begin
    if (sdone === 1'b1) begin
      for (int i = 0; i < NUM_KEYS; i++) begin
        nf[i] = 0;
        if (pend) cal[i] = 1;
      end
      pend = 0;
    end
  end
  always begin : mon
    int k, s, lv, i;
    bit st;
    @(posedge clk_i);
    if (acqv === 1'b1 && !reset_i) begin
      k = int'(bkey);
      s = int'(acqs);
      @(posedge clk_i);
      #1;
      st = 0;
      if (cal[k] || (rcl === 1'b1 && k == 5 && ac[5])) begin
        if (!cal[k]) chk("stuck time", 1, act5 > 180 && act5 < 1500);
        chk("recal", 1, rcl);
        chk("recal key", k, 32'(rkey));
        cal[k] = 0;
        rf[k] = s;
        fc[k] = 0;
        nc[k] = 0;
        ac[k] = 0;
      end else begin
        lv = ac[k] ? thr[k] - thr[k] / 8 : thr[k];
        if (s + lv <= rf[k]) begin
          fc[k]++;
          if (fc[k] >= fl[k]) begin
            fc[k] = 0;
            if (!nf[k]) nc[k]++;
            nf[k] = 1;
            if (nc[k] >= nl[k]) ac[k] = 1;
          end else st = 1;
        end else begin
          fc[k] = 0;
          nc[k] = 0;
          ac[k] = 0;
        end
        chk("recal", 0, rcl);
        if (k == 5 && ac[5]) chk("stuck late", 1, act5 < 1500);
      end
      chk("key_active", 32'(ac[k]), 32'(act[k]));
      if (!nochk) begin
        i = 0;
        while (breq !== 1'b1 && i < 40) begin
          @(posedge clk_i);
          #1;
          i++;
        end
        chk("next key", st ? k : nxt(k), 32'(bkey));
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    test_done();
  end
  initial begin
    logic [31:0] r;
    int kk;
    for (int k = 0; k < NUM_KEYS; k++) begin
      cal[k] = 1;
      thr[k] = 10;
      fl[k] = 5;
      nl[k] = 2;
      sg[k] = bs(k);
    end
    put();
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    chk("reset outputs", 32'h0000_0001, {act, breq, rcl, sdone, wrq});
    bus(0, 10'h000, 0);
    chk("setup default", SETUP_DEFAULT, bq);
    bus(0, 10'h05C, 0);
    chk("setup default", SETUP_DEFAULT, bq);
    bus(0, 10'h060, 0);
    chk("unmapped", 0, bq);
    bus(1, 10'h200, 32'hFFFF_FFFF);
    bus(0, 10'h200, 0);
    chk("unmapped", 0, bq);
    bus(0, 10'h080, 0);
    chk("control", 32'h0000_0001, bq);
    $display("test defaults done");
    // Scan paused so no result races a setup change
    nochk = 1;
    bus(1, 10'h080, 0);
    repeat (100) @(posedge clk_i);
    for (int k = 0; k < NUM_KEYS; k++) begin
      thr[k] = 4 + int'(xs() % 16);
      fl[k] = (k == 4) ? 1 : 1 + int'(xs() % 15);
      nl[k] = (k == 2) ? 0 : 1 + int'(xs() % 3);
      bus(1, ADDR_W'(4 * k), {4'(thr[k] - 4), DEF_UP, 4'hF, 4'(fl[k]), 8'(nl[k]), k == 5 ? 8'h01 : 8'h00});
    end
    bus(1, 10'h080, 32'h0000_0003);
    pend = 1;
    nochk = 0;
    repeat (600) @(posedge clk_i);
    $display("test config done");
    sg[5] = bs(5) - 40;
    for (int p = 0; p < 12; p++) begin
      r = xs();
      slow <= r[0];
      for (int k = 0; k < NUM_KEYS; k++) begin
        r = xs();
        if (k != 5 && r[1:0] == 2'b00) sg[k] = bs(k) - thr[k] + 2 - int'(r[4:2] % 6);
      end
      if (p == 11) sg[5] = bs(5) - 80;
      put();
      repeat (600) @(posedge clk_i);
      for (int k = 0; k < NUM_KEYS; k++) if (k != 5) sg[k] = bs(k);
      put();
      repeat (600) @(posedge clk_i);
      kk = int'(xs() % 24);
      if (kk != 5 && p < 11) begin
        bus(0, ADDR_W'(32'h0000_0100 + 4 * kk), 0);
        chk("reference", 32'(rf[kk]), bq);
      end
    end
    $display("test phases done");
    // Key 0 slews one count per drift period toward a raised signal, then back
    bus(1, 10'h000, {4'(thr[0] - 4), 4'h2, 4'h1, 4'(fl[0]), 8'(nl[0]), 8'h00});
    sg[0] = bs(0) + 3;
    put();
    repeat (100) @(posedge clk_i);
    bus(0, 10'h100, 0);
    chk("drift slew", 1, bq < bs(0) + 3);
    repeat (1500) @(posedge clk_i);
    bus(0, 10'h100, 0);
    chk("drift up", bs(0) + 3, bq);
    sg[0] = bs(0);
    put();
    repeat (1500) @(posedge clk_i);
    bus(0, 10'h100, 0);
    chk("drift down", bs(0), bq);
    r = '0;
    for (int k = 0; k < NUM_KEYS; k++) r[k] = ac[k];
    bus(0, 10'h084, 0);
    chk("active word", r, bq);
    $display("test drift done");
    test_done();
  end
endmodule // tkdf_filter_tb_top
`default_nettype wire

//--- tkdf_mem_if.sv
// Link between the filter core and its setup store
`timescale 1ns/1ps
`default_nettype none
interface tkdf_mem_if;
  import tkdf_pkg::*;
  logic [KEY_W-1:0] a_idx;
  logic             a_we;
  logic [31:0]      a_wdata;
  logic [31:0]      a_rdata;
  logic [KEY_W-1:0] b_idx;
  logic [31:0]      b_rdata;
  modport mem  (input a_idx, a_we, a_wdata, b_idx, output a_rdata, b_rdata);
  modport user (output a_idx, a_we, a_wdata, b_idx, input a_rdata, b_rdata);
endinterface
`default_nettype wire

//--- tkdf_pkg.sv
// Shared constants, setup word layout and drift lookup for the touch key filter
package tkdf_pkg;

  localparam int NUM_KEYS = 24;
  localparam int KEY_W    = 5;
  localparam int SIG_W    = 16;
  localparam int DCNT_W   = 8;
  localparam int RCNT_W   = 12;
  localparam int ADDR_W   = 10;

  // Timing: one base tick steps every per-key timer
  localparam int CLK_HZ           = 20_000_000;
  localparam int TICK_MS          = 50;
  localparam int TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  localparam int DOWN_STEP_MS     = 250;
  localparam int DOWN_STEP_TICKS  = DOWN_STEP_MS / TICK_MS;
  localparam int RECAL_STEP_MS    = 500;
  localparam int RECAL_STEP_TICKS = RECAL_STEP_MS / TICK_MS;

  localparam logic [7:0]       RECAL_MAX_CODE = 8'hFE;
  localparam logic [7:0]       RECAL_BAD_CODE = 8'hFF;
  localparam logic [SIG_W-1:0] THR_OFFSET     = 16'h0004;

  // Setup word fields
  localparam int RD_LSB = 0;
  localparam int NL_LSB = 8;
  localparam int FL_LSB = 16;
  localparam int DD_LSB = 20;
  localparam int UD_LSB = 24;
  localparam int TT_LSB = 28;

  localparam logic [7:0] DEF_RECAL  = 8'h14;
  localparam logic [7:0] DEF_NORMAL = 8'h02;
  localparam logic [3:0] DEF_FAST   = 4'h5;
  localparam logic [3:0] DEF_DOWN   = 4'hA;
  localparam logic [3:0] DEF_UP     = 4'h4;
  localparam logic [3:0] DEF_THR    = 4'h6;
  localparam logic [31:0] SETUP_DEFAULT = {DEF_THR, DEF_UP, DEF_DOWN, DEF_FAST, DEF_NORMAL, DEF_RECAL};

  // Register map (byte addresses)
  localparam logic [2:0] REGION_SETUP = 3'h0;
  localparam logic [2:0] REGION_MISC  = 3'h1;
  localparam logic [2:0] REGION_REF   = 3'h2;
  localparam logic [4:0] CTRL_WORD    = 5'h00;
  localparam logic [4:0] ACTIVE_WORD  = 5'h01;
  localparam int CTRL_SCAN_BIT   = 0;
  localparam int CTRL_CALALL_BIT = 1;

  // Upward drift period in base ticks, indexed by setup code
  function automatic logic [DCNT_W-1:0] up_drift_ticks(input logic [3:0] code);
    logic [DCNT_W-1:0] t;
    t = 8'h02;
    unique case (code)
      4'h0, 4'h1: t = 8'h02;
      4'h2:       t = 8'h04;
      4'h3:       t = 8'h08;
      4'h4:       t = 8'h0C;
      4'h5:       t = 8'h10;
      4'h6:       t = 8'h14;
      4'h7:       t = 8'h1C;
      4'h8:       t = 8'h28;
      4'h9:       t = 8'h3C;
      4'hA:       t = 8'h50;
      4'hB:       t = 8'h64;
      4'hC:       t = 8'h8C;
      4'hD:       t = 8'hB4;
      4'hE:       t = 8'hDC;
      4'hF:       t = 8'hFF;
    endcase
    return t;
  endfunction

endpackage

//--- tkdf_setup_mem.sv
// Per-key setup store, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module tkdf_setup_mem
  import tkdf_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  tkdf_mem_if.mem   mem
);

  logic [31:0] word_r [NUM_KEYS];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_KEYS; i++) begin
        word_r[i] <= SETUP_DEFAULT;
      end
    end else if (mem.a_we && (int'(mem.a_idx) < NUM_KEYS)) begin
      word_r[mem.a_idx] <= mem.a_wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mem.a_rdata <= '0;
      mem.b_rdata <= SETUP_DEFAULT;
    end else begin
      mem.a_rdata <= (int'(mem.a_idx) < NUM_KEYS) ? word_r[mem.a_idx] : '0;
      mem.b_rdata <= (int'(mem.b_idx) < NUM_KEYS) ? word_r[mem.b_idx] : '0;
    end
  end

endmodule // tkdf_setup_mem
`default_nettype wire

//--- tkdf_tick.sv
// Base tick divider for the per-key timers
`timescale 1ns/1ps
`default_nettype none
module tkdf_tick
  import tkdf_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  output logic      tick_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r == LAST);
      cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    end
  end

endmodule // tkdf_tick
`default_nettype wire
